// File: pkg/mpt_pkg.sv
package mpt_pkg;
   localparam int          NTMR       = 5;
   localparam logic [2:0]  TMR_LAST   = 3'h4;
   localparam logic [4:0]  OFS_CTRL   = 5'h00;
   localparam logic [4:0]  OFS_HIGH   = 5'h04;
   localparam logic [4:0]  OFS_LOW    = 5'h08;
   localparam logic [4:0]  OFS_CMD    = 5'h0c;
   localparam logic [4:0]  OFS_STAT   = 5'h10;
   localparam int          CF_EN      = 0;
   localparam int          CF_PRE     = 1;
   localparam int          CF_RISE    = 6;
   localparam int          CF_PER     = 7;
   localparam int          CF_OUT     = 8;
   localparam int          CF_EXT     = 9;
   localparam int          CF_INVC    = 10;
   localparam int          CF_PINV    = 11;
   localparam int          CF_GOFF    = 12;
   localparam int          CF_MODE    = 13;
   localparam logic [15:0] CTRL_RST   = 16'h1000;
   localparam logic [4:0]  PRE_MAX    = 5'h10;
   localparam logic [1:0]  MODE_TMR   = 2'h0;
   localparam logic [1:0]  MODE_DS    = 2'h1;
   localparam logic [1:0]  MODE_CNT   = 2'h2;
   localparam int          CMD_START  = 0;
   localparam int          CMD_STOP   = 1;
   localparam int          CMD_RPT    = 2;
   localparam int          ST_RUN     = 0;
   localparam int          ST_OUT     = 1;
   localparam int          ST_RISE    = 2;
   localparam int          ST_PER     = 3;
   localparam int          ST_CNT     = 16;
   localparam logic [2:0]  HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {CH_IDLE = 2'b01, CH_RUN = 2'b10} mpt_ch_state_t;

   typedef struct packed {
      mpt_ch_state_t st;
      logic [15:0]   pre;
      logic [15:0]   cnt;
      logic [15:0]   acc;
      logic [4:0]    idx;
      logic          inv_clk;
      logic          pwm_inv;
      logic          goff;
      logic          ext;
      logic [1:0]    mode;
      logic          rpt;
      logic          out;
      logic          rise;
      logic          per;
      logic          ext_d;
   } mpt_ch_t;

   localparam mpt_ch_t CH_RST = '{st: CH_IDLE, default: '0};

   function automatic logic [15:0] mpt_mask(input logic [4:0] idx);
      mpt_mask = (idx >= PRE_MAX) ? 16'hffff
                                  : 16'((17'h1 << idx) - 17'h1);
   endfunction
endpackage

// File: pkg/mpt_tmr_if.sv
`timescale 1ns/100ps
interface mpt_tmr_if;
   logic [15:0] ctrl;
   logic [15:0] high_count;
   logic [15:0] low_count;
   logic        start;
   logic        stop;
   logic        repeat_mode;
   logic        running;
   logic        out;
   logic        pin;
   logic        rise_event;
   logic        period_event;
   logic [15:0] count;
   modport regs (output ctrl, high_count, low_count, start, stop,
                 repeat_mode, input running, out, pin, rise_event,
                 period_event, count);
   modport chan (input ctrl, high_count, low_count, start, stop,
                 repeat_mode, output running, out, pin, rise_event,
                 period_event, count);
endinterface

// File: verilog/mpt_sync.sv
`timescale 1ns/100ps
module mpt_sync
   import mpt_pkg::*;
#(
   parameter int W = 2
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } mpt_sync_t;

   mpt_sync_t r;
   mpt_sync_t r_next;

   always_comb begin
      r_next    = r;
      r_next.s1 = d;
      r_next.s2 = r.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else if (ce) begin
         r <= r_next;
      end
   end

   assign q = r.s2;
endmodule // mpt_sync

// File: verilog/mpt_chan.sv
`timescale 1ns/100ps
module mpt_chan
   import mpt_pkg::*;
#(
   parameter bit HAS_PINS = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic ext_clk_s,
   input  wire logic gate_s,
   mpt_tmr_if.chan   tif
);
   mpt_ch_t     q;
   mpt_ch_t     n;
   logic [15:0] msk;
   logic [15:0] cnt_n;
   logic        tick;
   logic        gate_act;
   logic        use_ext;
   logic        ext_edge;
   logic        step;
   logic        ds_c;

   always_comb begin
      n       = q;
      n.rise  = 1'b0;
      n.per   = 1'b0;
      n.ext_d = ext_clk_s;
      msk     = mpt_mask(q.idx);
      tick    = (q.pre & msk) == msk;
      // Gating is a sampled level; pulses under one clock may be missed.
      gate_act = HAS_PINS && !q.goff && gate_s == q.inv_clk;
      use_ext  = HAS_PINS && q.ext && q.mode == MODE_CNT;
      ext_edge = (ext_clk_s ^ q.inv_clk) && !(q.ext_d ^ q.inv_clk);
      step     = !gate_act && (use_ext ? ext_edge : tick);
      cnt_n    = q.cnt + 16'h1;
      ds_c     = 1'b0;
      case (q.st)
         CH_IDLE: begin
            if (tif.start) begin
               n.st      = CH_RUN;
               n.idx     = (tif.ctrl[CF_PRE +: 5] > PRE_MAX) ? PRE_MAX
                                                          : tif.ctrl[CF_PRE +: 5];
               n.inv_clk = tif.ctrl[CF_INVC];
               n.pwm_inv = tif.ctrl[CF_PINV];
               n.goff    = tif.ctrl[CF_GOFF];
               n.ext     = tif.ctrl[CF_EXT];
               n.mode    = (!HAS_PINS && tif.ctrl[CF_MODE +: 2] == MODE_CNT)
                           ? MODE_TMR : tif.ctrl[CF_MODE +: 2];
               n.rpt     = tif.repeat_mode;
               n.pre     = 16'h0;
               n.cnt     = 16'h0;
               n.acc     = 16'h0;
               n.out     = 1'b0;
            end
         end
         CH_RUN: begin
            if (!gate_act) begin
               n.pre = q.pre + 16'h1;
            end
            if (tif.stop) begin
               n.st  = CH_IDLE;
               n.out = 1'b0;
            end else if (step && q.mode == MODE_DS) begin
               {ds_c, n.acc} = {1'b0, q.acc} + {1'b0, tif.high_count};
               n.out         = ds_c;
            end else if (step) begin
               n.cnt = cnt_n;
               if (cnt_n == tif.high_count) begin
                  n.out  = q.mode != MODE_CNT;
                  n.rise = 1'b1;
               end
               if (cnt_n == tif.low_count) begin
                  n.out = 1'b0;
                  n.per = 1'b1;
                  n.cnt = 16'h0;
                  if (!q.rpt) begin
                     n.st = CH_IDLE;
                  end
               end
            end
         end
         default: n = CH_RST;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= CH_RST;
      end else if (ce) begin
         q <= n;
      end
   end

   assign tif.pin          = (q.out && !gate_act) ^ q.pwm_inv;
   assign tif.out          = q.out;
   assign tif.running      = q.st == CH_RUN;
   assign tif.rise_event   = q.rise;
   assign tif.period_event = q.per;
   assign tif.count        = q.cnt;

   property p_tick_div2;
      @(posedge clk) disable iff (!rst_n)
      ce && q.st == CH_RUN && q.idx == 5'h01 && tick && !gate_act
      |=> !ce || !tick;
   endproperty
   a_tick_div2: assert property (p_tick_div2)
      else $error("Prescale by two ticked twice in a row.");

   property p_rise_out;
      @(posedge clk) disable iff (!rst_n)
      q.rise && q.mode != MODE_CNT && !q.per |-> q.out;
   endproperty
   a_rise_out: assert property (p_rise_out)
      else $error("Rise event without a high output.");

   property p_single_halt;
      @(posedge clk) disable iff (!rst_n)
      q.per && !q.rpt |-> q.st == CH_IDLE && !q.out;
   endproperty
   a_single_halt: assert property (p_single_halt)
      else $error("Single shot did not halt at the period end.");

   property p_repeat_restart;
      @(posedge clk) disable iff (!rst_n)
      q.per && q.rpt |-> q.st == CH_RUN && q.cnt == 16'h0;
   endproperty
   a_repeat_restart: assert property (p_repeat_restart)
      else $error("Repeat did not restart from zero.");

   property p_gate_hold;
      @(posedge clk) disable iff (!rst_n)
      ce && q.st == CH_RUN && gate_act |=> $stable(q.cnt);
   endproperty
   a_gate_hold: assert property (p_gate_hold)
      else $error("Count moved while gated.");

   property p_latched_cfg;
      @(posedge clk) disable iff (!rst_n)
      q.st == CH_RUN ##1 q.st == CH_RUN
      |-> $stable(q.idx) && $stable(q.pwm_inv) && $stable(q.goff);
   endproperty
   a_latched_cfg: assert property (p_latched_cfg)
      else $error("Setting changed during an active cycle.");

   property p_no_count_mode;
      @(posedge clk) disable iff (!rst_n)
      !HAS_PINS |-> q.mode != MODE_CNT && !gate_act;
   endproperty
   a_no_count_mode: assert property (p_no_count_mode)
      else $error("Input-based mode on an instance without inputs.");
endmodule // mpt_chan

// File: verilog/mpt_top.sv
`timescale 1ns/100ps
// Overview of operation
// - Five timers; only timer zero has inputs.
// - Tick is source clock over two^index.
// - Rise interrupt on output low-to-high, if enabled.
// - Period interrupt on high-to-low period end.
// - Counter mode interrupts at target counts.
// - Pin driven only with output enable set.
// - Output enable takes timer pins from GPIO.
// - Timer zero external clock only in counter mode.
// - External clock comes from digital pin eight.
// - Counter mode counts incoming clock edges.
// - Invert setting picks gate level and edge.
// - Gating works with the internal clock.
// - Timer mode runs single shot or repeat.
// - Gate input pauses the counter, timer zero.
// - Gating off ignores the gate input.
// - Every timer can invert its PWM output.
// - Output high after high_count, low after low_count.
// - Repeat restarts the cycle until stopped.
// - Single counter mode halts at second target.
// - Repeat counter mode restarts from zero.
module mpt_top
   import mpt_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        CE,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        DIG_PIN_EIGHT,
   input  wire logic        GATE_IN,
   output logic      [4:0]  PWM_OUT,
   output logic      [4:0]  PWM_OE_N,
   output logic      [4:0]  GPIO_BLOCK,
   output logic      [4:0]  TMR_IRQ
);
   typedef struct packed {
      logic [NTMR-1:0][15:0] ctrl;
      logic [NTMR-1:0][15:0] high;
      logic [NTMR-1:0][15:0] low;
      logic [NTMR-1:0]       start;
      logic [NTMR-1:0]       stop;
      logic [NTMR-1:0]       rpt;
      logic [NTMR-1:0]       rise_f;
      logic [NTMR-1:0]       per_f;
      logic [31:0]           rdata;
      logic                  wr;
      logic [7:0]            waddr;
      logic                  ready;
      logic [NTMR-1:0]       pwm;
      logic [NTMR-1:0]       oe_n;
      logic [NTMR-1:0]       gpio_blk;
      logic [NTMR-1:0]       irq;
   } mpt_top_t;

   localparam mpt_top_t TOP_RST = '{ctrl:  {NTMR{CTRL_RST}},
                                    ready: 1'b1,
                                    oe_n:  {NTMR{1'b1}},
                                    default: '0};

   mpt_top_t              q;
   mpt_top_t              n;
   logic [1:0]            pin_s;
   logic [NTMR-1:0]       ch_run;
   logic [NTMR-1:0]       ch_out;
   logic [NTMR-1:0]       ch_pin;
   logic [NTMR-1:0]       ch_rise;
   logic [NTMR-1:0]       ch_per;
   logic [NTMR-1:0][15:0] ch_cnt;
   logic [2:0]            wt;
   logic [4:0]            wo;
   logic [2:0]            rt;
   logic [4:0]            ro;
   logic                  rd_ok;
   logic                  wr_ok;

   mpt_tmr_if tif [NTMR] ();

   // Pin eight and the gate pin both come from outside the clock domain.
   mpt_sync #(
      .W (2)
   ) u_sync (
      .clk   (CLK),
      .rst_n (RST_N),
      .ce    (CE),
      .d     ({GATE_IN, DIG_PIN_EIGHT}),
      .q     (pin_s)
   );

   for (genvar g = 0; g < NTMR; g++) begin : g_tmr
      assign tif[g].ctrl        = q.ctrl[g];
      assign tif[g].high_count  = q.high[g];
      assign tif[g].low_count   = q.low[g];
      assign tif[g].start       = q.start[g];
      assign tif[g].stop        = q.stop[g];
      assign tif[g].repeat_mode = q.rpt[g];
      assign ch_run[g]          = tif[g].running;
      assign ch_out[g]          = tif[g].out;
      assign ch_pin[g]          = tif[g].pin;
      assign ch_rise[g]         = tif[g].rise_event;
      assign ch_per[g]          = tif[g].period_event;
      assign ch_cnt[g]          = tif[g].count;

      mpt_chan #(
         .HAS_PINS (g == 0)
      ) u_chan (
         .clk       (CLK),
         .rst_n     (RST_N),
         .ce        (CE),
         .ext_clk_s (pin_s[0]),
         .gate_s    (pin_s[1]),
         .tif       (tif[g])
      );
   end

   always_comb begin
      n       = q;
      n.start = '0;
      n.stop  = '0;
      wt      = q.waddr[7:5];
      wo      = q.waddr[4:0];
      rt      = HADDR[7:5];
      ro      = HADDR[4:0];
      rd_ok   = HSEL && HTRANS[1] && HREADY && !HWRITE
                && HADDR[31:8] == 24'h0 && rt <= TMR_LAST;
      wr_ok   = HSEL && HTRANS[1] && HREADY && HWRITE
                && HSIZE == HSIZE_WORD && HADDR[31:8] == 24'h0;
      if (q.wr && wt <= TMR_LAST) begin
         case (wo)
            OFS_CTRL: n.ctrl[wt] = HWDATA[15:0];
            OFS_HIGH: n.high[wt] = HWDATA[15:0];
            OFS_LOW:  n.low[wt]  = HWDATA[15:0];
            OFS_CMD: begin
               // A start on a timer that is not enabled is dropped.
               n.start[wt] = HWDATA[CMD_START] && q.ctrl[wt][CF_EN];
               n.stop[wt]  = HWDATA[CMD_STOP];
               if (HWDATA[CMD_START]) begin
                  n.rpt[wt] = HWDATA[CMD_RPT];
               end
            end
            default: ;
         endcase
      end
      n.wr    = wr_ok;
      n.waddr = HADDR[7:0];
      n.rdata = 32'h0;
      if (rd_ok) begin
         case (ro)
            OFS_CTRL: n.rdata[15:0]     = q.ctrl[rt];
            OFS_HIGH: n.rdata[15:0]     = q.high[rt];
            OFS_LOW:  n.rdata[15:0]     = q.low[rt];
            OFS_CMD:  n.rdata[CMD_RPT]  = q.rpt[rt];
            OFS_STAT: begin
               n.rdata[ST_RUN]      = ch_run[rt];
               n.rdata[ST_OUT]      = ch_out[rt];
               n.rdata[ST_RISE]     = q.rise_f[rt];
               n.rdata[ST_PER]      = q.per_f[rt];
               n.rdata[ST_CNT +: 16] = ch_cnt[rt];
               n.rise_f[rt]         = 1'b0;
               n.per_f[rt]          = 1'b0;
            end
            default: ;
         endcase
      end
      // Set after clear, so an event in the reading cycle is kept.
      n.rise_f = n.rise_f | ch_rise;
      n.per_f  = n.per_f | ch_per;
      n.ready  = 1'b1;
      for (int i = 0; i < NTMR; i++) begin
         n.irq[i]      = (n.rise_f[i] && q.ctrl[i][CF_RISE])
                         || (n.per_f[i] && q.ctrl[i][CF_PER]);
         n.gpio_blk[i] = q.ctrl[i][CF_OUT];
         n.oe_n[i]     = !(q.ctrl[i][CF_OUT] && q.ctrl[i][CF_EN]
                           && q.ctrl[i][CF_MODE +: 2] != MODE_CNT);
         n.pwm[i]      = ch_pin[i];
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         q <= TOP_RST;
      end else if (CE) begin
         q <= n;
      end
   end

   assign HRDATA     = q.rdata;
   assign HREADYOUT  = q.ready;
   assign HRESP      = 1'b0;
   assign PWM_OUT    = q.pwm;
   assign PWM_OE_N   = q.oe_n;
   assign GPIO_BLOCK = q.gpio_blk;
   assign TMR_IRQ    = q.irq;

   property p_rise_irq;
      @(posedge CLK) disable iff (!RST_N)
      CE && ch_rise[0] && q.ctrl[0][CF_RISE] |=> TMR_IRQ[0];
   endproperty
   a_rise_irq: assert property (p_rise_irq)
      else $error("Rise event did not raise the interrupt.");

   property p_per_irq;
      @(posedge CLK) disable iff (!RST_N)
      CE && ch_per[3] && q.ctrl[3][CF_PER] |=> TMR_IRQ[3];
   endproperty
   a_per_irq: assert property (p_per_irq)
      else $error("Period event did not raise the interrupt.");

   property p_no_irq;
      @(posedge CLK) disable iff (!RST_N)
      CE && !q.ctrl[2][CF_RISE] && !q.ctrl[2][CF_PER] |=> !TMR_IRQ[2];
   endproperty
   a_no_irq: assert property (p_no_irq)
      else $error("Interrupt raised with both enables clear.");

   property p_flag_held;
      @(posedge CLK) disable iff (!RST_N)
      CE && ch_per[1] |=> q.per_f[1] ##1 (q.per_f[1] || $past(rd_ok));
   endproperty
   a_flag_held: assert property (p_flag_held)
      else $error("Period flag lost before a status read.");

   property p_gpio_block;
      @(posedge CLK) disable iff (!RST_N)
      CE |=> GPIO_BLOCK[4] == $past(q.ctrl[4][CF_OUT]);
   endproperty
   a_gpio_block: assert property (p_gpio_block)
      else $error("Pin release does not follow output enable.");

   property p_pin_off;
      @(posedge CLK) disable iff (!RST_N)
      CE && !q.ctrl[0][CF_OUT] |=> PWM_OE_N[0];
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("Pin driven with output enable clear.");

   property p_start_disabled;
      @(posedge CLK) disable iff (!RST_N)
      CE && q.wr && q.waddr == {3'h0, OFS_CMD} && !q.ctrl[0][CF_EN]
      |=> !q.start[0];
   endproperty
   a_start_disabled: assert property (p_start_disabled)
      else $error("Start accepted on a disabled timer.");

   property p_read_ctrl;
      @(posedge CLK) disable iff (!RST_N)
      CE && rd_ok && rt == 3'h1 && ro == OFS_CTRL
      |=> HRDATA == {16'h0, $past(q.ctrl[1])};
   endproperty
   a_read_ctrl: assert property (p_read_ctrl)
      else $error("Control read returned the wrong value.");

   property p_stat_clear;
      @(posedge CLK) disable iff (!RST_N)
      CE && rd_ok && rt == 3'h2 && ro == OFS_STAT && !ch_rise[2]
      |=> !q.rise_f[2];
   endproperty
   a_stat_clear: assert property (p_stat_clear)
      else $error("Status read did not clear the rise flag.");

   property p_rise_flag;
      @(posedge CLK) disable iff (!RST_N)
      CE && ch_rise[0] |=> q.rise_f[0];
   endproperty
   a_rise_flag: assert property (p_rise_flag)
      else $error("Rise event was not latched.");

   property p_pin_follow;
      @(posedge CLK) disable iff (!RST_N)
      CE |=> PWM_OUT[1] == $past(ch_pin[1]);
   endproperty
   a_pin_follow: assert property (p_pin_follow)
      else $error("Pin output does not follow the timer.");

   property p_gpio_free;
      @(posedge CLK) disable iff (!RST_N)
      CE && !q.ctrl[2][CF_OUT] |=> !GPIO_BLOCK[2];
   endproperty
   a_gpio_free: assert property (p_gpio_free)
      else $error("Pins kept from GPIO with output enable clear.");
endmodule // mpt_top

// File: test/mpt_pins_model.sv
`timescale 1ns/100ps
// Stands for the pins outside timer zero: clock pin eight and the gate.
module mpt_pins_model (
   input  wire logic clk,
   output logic      pin_eight,
   output logic      gate_pin
);
   initial begin
      pin_eight = 1'b0;
      gate_pin  = 1'b1;
   end

   // Pulses last three cycles so the two-flop sampling never misses one.
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         pin_eight <= 1'b1;
         repeat (3) @(posedge clk);
         pin_eight <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask

   task automatic set_gate(input logic v);
      @(posedge clk);
      gate_pin <= v;
   endtask
endmodule // mpt_pins_model

// File: test/tb_top.sv
`timescale 1ns/100ps
module tb_top
   import mpt_pkg::*;
;
   typedef struct {
      logic [31:0] a;
      logic        w;
      logic [31:0] d;
      logic [31:0] e;
   } mpt_row_t;

   logic        clk;
   logic        rst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        pin_eight;
   logic        gate_pin;
   logic [4:0]  pwm_out;
   logic [4:0]  pwm_oe_n;
   logic [4:0]  gpio_block;
   logic [4:0]  tmr_irq;
   logic [31:0] q;
   logic        ce;
   int          cyc;
   int          fails;
   int          total_checks;

   // Writes that must be ignored are read back as zero.
   mpt_row_t rows [7] = '{
      '{32'h0000_0004, 1'b1, 32'h0000_abcd, 32'h0000_abcd},
      '{32'h0000_0028, 1'b1, 32'h0000_5a5a, 32'h0000_5a5a},
      '{32'h0000_0080, 1'b0, 32'h0000_0000, 32'h0000_1000},
      '{32'h0000_00a0, 1'b1, 32'h0000_ffff, 32'h0000_0000},
      '{32'h0000_0014, 1'b1, 32'h0000_ffff, 32'h0000_0000},
      '{32'h0000_0104, 1'b1, 32'h0000_ffff, 32'h0000_0000},
      '{32'h0000_0004, 1'b0, 32'h0000_0000, 32'h0000_abcd}};

   mpt_top mpt_top_inst (
      .CLK           (clk),
      .RST_N         (rst_n),
      .CE            (ce),
      .HSEL          (hsel),
      .HADDR         (haddr),
      .HTRANS        (htrans),
      .HWRITE        (hwrite),
      .HSIZE         (hsize),
      .HWDATA        (hwdata),
      .HREADY        (hready),
      .HRDATA        (hrdata),
      .HREADYOUT     (hready),
      .HRESP         (hresp),
      .DIG_PIN_EIGHT (pin_eight),
      .GATE_IN       (gate_pin),
      .PWM_OUT       (pwm_out),
      .PWM_OE_N      (pwm_oe_n),
      .GPIO_BLOCK    (gpio_block),
      .TMR_IRQ       (tmr_irq)
   );

   mpt_pins_model mpt_pins_model_inst (
      .clk       (clk),
      .pin_eight (pin_eight),
      .gate_pin  (gate_pin)
   );

   always #50 clk = ~clk;

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic timeout();
      fails++;
      end_of_test();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) timeout();
   endtask

   // The master holds each phase until it samples ready high.
   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask

   function automatic logic [31:0] ra(input int t, input logic [4:0] ofs);
      ra = {24'h0, 3'(t), ofs};
   endfunction

   task automatic cfg(input int t, input logic [15:0] c,
                      input logic [15:0] hi, input logic [15:0] lo);
      xfer(1'b1, ra(t, OFS_CTRL), {16'h0, c});
      xfer(1'b1, ra(t, OFS_HIGH), {16'h0, hi});
      xfer(1'b1, ra(t, OFS_LOW), {16'h0, lo});
   endtask

   task automatic wait_pin(input int t, input logic lvl, output int n);
      n = 0;
      while (pwm_out[t] !== lvl && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) timeout();
   endtask

   // Timers one to four keep gating off, as software must for them.
   task automatic pwm_run(input int t, input int p, input int hi,
                          input int lo, input logic inv);
      int n;
      cfg(t, 16'h11c1 | 16'(p << CF_PRE) | (16'(inv) << CF_PINV), 16'(hi),
          16'(lo));
      chk(32'({pwm_oe_n[t], gpio_block[t]}), 32'h1);
      chk(32'(pwm_out[t]), 32'h0);
      xfer(1'b1, ra(t, OFS_CMD), 32'h5);
      // Start latches the inversion, so wait for the new idle level first.
      wait_pin(t, inv, n);
      wait_pin(t, !inv, n);
      wait_pin(t, inv, n);
      chk(32'(n), 32'((lo - hi) << p));
      wait_pin(t, !inv, n);
      chk(32'(n), 32'(hi << p));
      chk(32'(tmr_irq[t]), 32'h1);
      xfer(1'b1, ra(t, OFS_CMD), 32'h2);
      // Running drops one edge after the stop write.
      @(posedge clk);
      xfer(1'b0, ra(t, OFS_STAT), 32'h0);
      chk(32'({q[3:2], q[0]}), 32'h6);
      xfer(1'b0, ra(t, OFS_STAT), 32'h0);
      chk(32'(q[3:2]), 32'h0);
   endtask

   initial begin
      clk          = 1'b0;
      rst_n        = 1'b0;
      hsel         = 1'b1;
      haddr        = 32'h0;
      htrans       = 2'h0;
      hwrite       = 1'b0;
      hsize        = HSIZE_WORD;
      hwdata       = 32'h0;
      ce           = 1'b1;
      fails        = 0;
      total_checks = 0;
      repeat (10) @(posedge clk);
      chk(32'(hready), 32'h1);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(32'({pwm_oe_n, gpio_block, tmr_irq, hresp}),
          32'({5'h1f, 5'h0, 5'h0, 1'b0}));
      for (int t = 0; t < NTMR; t++) begin
         xfer(1'b0, ra(t, OFS_CTRL), 32'h0);
         chk(q, 32'h0000_1000);
      end
      foreach (rows[i]) begin
         if (rows[i].w) xfer(1'b1, rows[i].a, rows[i].d);
         xfer(1'b0, rows[i].a, 32'h0);
         chk(q, rows[i].e);
      end
      pwm_run(1, 0, 2, 5, 1'b0);
      pwm_run(2, 1, 3, 4, 1'b0);
      pwm_run(3, 2, 1, 3, 1'b1);
      pwm_run(4, 0, 4, 6, 1'b1);
      // Half-scale delta-sigma toggles on every tick, one period per tick pair.
      cfg(2, 16'h31c3, 16'h8000, 16'h0);
      xfer(1'b1, ra(2, OFS_CMD), 32'h1);
      wait_pin(2, 1'b1, cyc);
      wait_pin(2, 1'b0, cyc);
      chk(32'(cyc), 32'h2);
      wait_pin(2, 1'b1, cyc);
      chk(32'(cyc), 32'h2);
      xfer(1'b1, ra(2, OFS_CMD), 32'h2);
      cfg(1, 16'h1001, 16'h100, 16'h200);
      xfer(1'b1, ra(1, OFS_CMD), 32'h1);
      repeat (4) @(posedge clk);
      xfer(1'b0, ra(1, OFS_STAT), 32'h0);
      cyc = int'(q[31:16]);
      // Clock enable low must freeze the count for the whole pause.
      ce <= 1'b0;
      repeat (30) @(posedge clk);
      ce <= 1'b1;
      xfer(1'b0, ra(1, OFS_STAT), 32'h0);
      chk(32'(q[31:16]) - 32'(cyc), 32'h2);
      xfer(1'b1, ra(1, OFS_CMD), 32'h2);
      for (int r = 0; r < 2; r++) begin
         cfg(0, 16'h52c1, 16'h2, 16'h4);
         xfer(1'b1, ra(0, OFS_CMD), 32'(1 | (r << CMD_RPT)));
         mpt_pins_model_inst.pulses(3);
         repeat (6) @(posedge clk);
         xfer(1'b0, ra(0, OFS_STAT), 32'h0);
         chk(q, 32'h0003_0005);
         mpt_pins_model_inst.pulses(1);
         repeat (6) @(posedge clk);
         chk(32'(tmr_irq[0]), 32'h1);
         xfer(1'b0, ra(0, OFS_STAT), 32'h0);
         chk(32'(q[3:0]), 32'({3'b100, r[0]}));
         xfer(1'b1, ra(0, OFS_CMD), 32'h2);
      end
      for (int v = 0; v < 2; v++) begin
         mpt_pins_model_inst.set_gate(v[0]);
         cfg(0, 16'h0001 | 16'(v << CF_INVC), 16'h3, 16'h64);
         xfer(1'b1, ra(0, OFS_CMD), 32'h5);
         repeat (20) @(posedge clk);
         xfer(1'b0, ra(0, OFS_STAT), 32'h0);
         chk(32'({q[31:16], q[0]}), 32'h1);
         mpt_pins_model_inst.set_gate(!v[0]);
         repeat (20) @(posedge clk);
         xfer(1'b0, ra(0, OFS_STAT), 32'h0);
         chk(32'(q[31:16] != 16'h0), 32'h1);
         xfer(1'b1, ra(0, OFS_CMD), 32'h2);
      end
      xfer(1'b1, ra(0, OFS_CTRL), 32'h1000);
      xfer(1'b1, ra(0, OFS_CMD), 32'h1);
      repeat (2) @(posedge clk);
      xfer(1'b0, ra(0, OFS_STAT), 32'h0);
      chk(32'(q[0]), 32'h0);
      end_of_test();
   end
endmodule // tb_top
